// File: dual_latch_pkg.sv
// Package for the dual gated latch: types and reset values
package dual_latch_pkg;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int unsigned NUM_LATCHES = 2;
  localparam logic Q_RESET_VAL = 1'b0;

  // ==========================================================================
  // Per-latch input group
  // ==========================================================================
  typedef struct packed {
    logic data;
    logic gate_n;
    logic set;
    logic reset;
  } latch_in_t;

  // ==========================================================================
  // Per-latch output group
  // ==========================================================================
  typedef struct packed {
    logic q;
    logic q_n;
  } latch_out_t;

endpackage

// File: dual_latch.sv
// Two gated D latches sharing one active-low strobe, clocked model
`timescale 1ns/10ps
module dual_latch #(
  parameter int unsigned LATCHES = dual_latch_pkg::NUM_LATCHES
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic strobe_n_i,
  input wire dual_latch_pkg::latch_in_t [LATCHES-1:0] latch_i,
  output dual_latch_pkg::latch_out_t [LATCHES-1:0] latch_o
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (LATCHES != dual_latch_pkg::NUM_LATCHES) begin : g_bad_count
    $error("dual_latch: LATCHES must be two");
  end
  if ($bits(dual_latch_pkg::latch_in_t) != 4) begin : g_bad_in
    $error("dual_latch: input group must be four bits");
  end
  if ($bits(dual_latch_pkg::latch_out_t) != 2) begin : g_bad_out
    $error("dual_latch: output group must be two bits");
  end

  // ==========================================================================
  // Effective strobe
  // ==========================================================================
  // Open only when both strobes are low; either high closes it
  function automatic logic latch_open(
    input logic shared_n,
    input logic gate_n
  );
    latch_open = ~shared_n & ~gate_n;
  endfunction

  // ==========================================================================
  // Per-latch action
  // ==========================================================================
  typedef enum {
    MODE_OPEN,
    MODE_CAPTURE,
    MODE_SET,
    MODE_RESET,
    MODE_HOLD
  } latch_mode_t;

  // Open wins; set beats reset in the unsupported overlap
  function automatic latch_mode_t latch_mode(
    input logic open,
    input logic was_open,
    input logic set,
    input logic reset
  );
    if (open) begin
      latch_mode = MODE_OPEN;
    end else if (set) begin
      latch_mode = MODE_SET;
    end else if (reset) begin
      latch_mode = MODE_RESET;
    end else if (was_open) begin
      latch_mode = MODE_CAPTURE;
    end else begin
      latch_mode = MODE_HOLD;
    end
  endfunction

  function automatic logic latch_value(
    input latch_mode_t mode,
    input logic data,
    input logic held
  );
    case (mode)
      MODE_OPEN: begin
        latch_value = data;
      end
      MODE_CAPTURE: begin
        // Value taken at the last open edge is kept
        latch_value = held;
      end
      MODE_SET: begin
        latch_value = 1'b1;
      end
      MODE_RESET: begin
        latch_value = 1'b0;
      end
      MODE_HOLD: begin
        latch_value = held;
      end
      default: begin
        // Unreachable; keeps the stored value safe
        latch_value = held;
      end
    endcase
  endfunction

  // Both rails from one value, so they can never agree
  function automatic dual_latch_pkg::latch_out_t rails(input logic value);
    rails.q = value;
    rails.q_n = ~value;
  endfunction

  // ==========================================================================
  // Input unpacking
  // ==========================================================================
  // Flat vectors keep the per-latch loops short
  logic [LATCHES-1:0] data_vec;
  logic [LATCHES-1:0] gate_n_vec;
  logic [LATCHES-1:0] set_vec;
  logic [LATCHES-1:0] reset_vec;

  always_comb begin
    data_vec = '0;
    gate_n_vec = '0;
    set_vec = '0;
    reset_vec = '0;
    for (int i = 0; i < LATCHES; i++) begin
      data_vec[i] = latch_i[i].data;
      gate_n_vec[i] = latch_i[i].gate_n;
      set_vec[i] = latch_i[i].set;
      reset_vec[i] = latch_i[i].reset;
    end
  end

  // ==========================================================================
  // Closing-edge tracking
  // ==========================================================================
  // Previous-cycle open state marks the rising strobe
  logic [LATCHES-1:0] open_vec;
  logic [LATCHES-1:0] open_reg;
  logic [LATCHES-1:0] open_next;

  always_comb begin
    open_vec = '0;
    for (int i = 0; i < LATCHES; i++) begin
      open_vec[i] = latch_open(strobe_n_i, gate_n_vec[i]);
    end
    open_next = open_vec;
  end

  // Strobe seen only at clock resolution; narrower pulses are missed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      open_reg <= '0;
    end else begin
      open_reg <= open_next;
    end
  end

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  // One action per latch per edge
  latch_mode_t mode_vec [LATCHES];

  always_comb begin
    for (int i = 0; i < LATCHES; i++) begin
      mode_vec[i] = latch_mode(open_vec[i], open_reg[i], set_vec[i], reset_vec[i]);
    end
  end

  // ==========================================================================
  // Stored value
  // ==========================================================================
  // Sampled each clock: an open latch copies data on the following edge,
  // so output trails the pin by one cycle instead of being truly combinational.
  logic [LATCHES-1:0] q_reg;
  logic [LATCHES-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < LATCHES; i++) begin
      q_next[i] = latch_value(mode_vec[i], data_vec[i], q_reg[i]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_reg <= {LATCHES{dual_latch_pkg::Q_RESET_VAL}};
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================================
  // Outputs, both rails registered
  // ==========================================================================
  dual_latch_pkg::latch_out_t [LATCHES-1:0] out_reg;
  dual_latch_pkg::latch_out_t [LATCHES-1:0] out_next;

  always_comb begin
    for (int i = 0; i < LATCHES; i++) begin
      out_next[i] = rails(q_next[i]);
    end
  end

  // Reset shows q low and q_n high

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LATCHES; i++) begin
        out_reg[i].q <= dual_latch_pkg::Q_RESET_VAL;
        out_reg[i].q_n <= ~dual_latch_pkg::Q_RESET_VAL;
      end
    end else begin
      out_reg <= out_next;
    end
  end

  assign latch_o = out_reg;

endmodule // dual_latch

// File: dual_latch_monitor.sv
// Checker for the dual gated latch
`timescale 1ns/10ps
module dual_latch_monitor #(parameter int unsigned LATCHES = 2) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic strobe_n_i,
  input wire dual_latch_pkg::latch_in_t [LATCHES-1:0] latch_i,
  input wire dual_latch_pkg::latch_out_t [LATCHES-1:0] latch_o
);
  // ====
  // Properties
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic o0 = !strobe_n_i && !latch_i[0].gate_n;
  wire logic o1 = !strobe_n_i && !latch_i[1].gate_n;
  property p_op0; o0 |=> latch_o[0].q == $past(latch_i[0].data); endproperty
  a_op0: assert property (p_op0) else $error("open 0");
  property p_op1; o1 |=> latch_o[1].q == $past(latch_i[1].data); endproperty
  a_op1: assert property (p_op1) else $error("open 1");
  property p_hd0; !o0 && !latch_i[0].set && !latch_i[0].reset |=> $stable(latch_o[0].q);
  endproperty
  a_hd0: assert property (p_hd0) else $error("hold 0");
  property p_hd1; !o1 && !latch_i[1].set && !latch_i[1].reset |=> $stable(latch_o[1].q);
  endproperty
  a_hd1: assert property (p_hd1) else $error("hold 1");
  property p_st0; !o0 && latch_i[0].set |=> latch_o[0].q; endproperty
  a_st0: assert property (p_st0) else $error("set 0");
  property p_rs1; !o1 && latch_i[1].reset && !latch_i[1].set |=> !latch_o[1].q; endproperty
  a_rs1: assert property (p_rs1) else $error("reset 1");
  property p_cp0; latch_o[0].q_n != latch_o[0].q; endproperty
  a_cp0: assert property (p_cp0) else $error("pair 0");
  property p_cp1; latch_o[1].q_n != latch_o[1].q; endproperty
  a_cp1: assert property (p_cp1) else $error("pair 1");
  c_op: cover property (o0 ##1 !o0);
  c_st: cover property (!o1 && latch_i[1].set);
  c_rs: cover property (!o0 && latch_i[0].reset);
endmodule // dual_latch_monitor
bind dual_latch dual_latch_monitor #(.LATCHES(LATCHES)) i_mon (.core_clk_i(core_clk_i),
  .rstn_i(rstn_i), .strobe_n_i(strobe_n_i), .latch_i(latch_i), .latch_o(latch_o));

// File: latch_driver.sv
// Model of the logic that drives the latch inputs
`timescale 1ns/10ps
module latch_driver (
  input wire logic clk_i,
  input wire logic [8:0] cmd_i,
  output logic strobe_n_o = 1'b1,
  output dual_latch_pkg::latch_in_t [1:0] lat_o = '0
);
  // ====
  // Registered drive, never set together with reset on either latch
  always @(posedge clk_i) begin
    strobe_n_o <= cmd_i[8];
    lat_o[1] <= {cmd_i[7:5], cmd_i[4] & ~cmd_i[5]};
    lat_o[0] <= {cmd_i[3:1], cmd_i[0] & ~cmd_i[1]};
  end
endmodule // latch_driver

// File: dual_latch_tb_top.sv
// Testbench for the dual gated latch
`timescale 1ns/10ps
module dual_latch_tb_top;
  // ====
  // Harness
  logic clk = 0;
  logic rstn = 0;
  logic [8:0] cmd = 9'h000;
  logic strobe_n;
  int bad_count = 0;
  int compares = 0;
  dual_latch_pkg::latch_in_t [1:0] li;
  dual_latch_pkg::latch_out_t [1:0] lo;
  initial forever #12.5 clk = ~clk;
  latch_driver i_latch_driver (.clk_i(clk), .cmd_i(cmd), .strobe_n_o(strobe_n), .lat_o(li));
  dual_latch i_dual_latch (.core_clk_i(clk), .rstn_i(rstn), .strobe_n_i(strobe_n),
    .latch_i(li), .latch_o(lo));
  task automatic ap(input logic [8:0] c, input logic [1:0] e);
    @(posedge clk) cmd <= c;
    repeat (2) @(posedge clk);
    #1 compares++;
    if ({lo[1].q, lo[0].q, lo[1].q_n, lo[0].q_n} !== {e, ~e}) begin
      bad_count++;
      $display("[FAIL] %0t q bad", $time);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_hold_capture;
    ap(9'h180, 2'b00);
    ap(9'h029, 2'b01);
    ap(9'h180, 2'b01);
    $display("t_hold_capture done");
  endtask
  task automatic t_gate_only;
    ap(9'h008, 2'b01);
    ap(9'h004, 2'b01);
    ap(9'h084, 2'b11);
    $display("t_gate_only done");
  endtask
  task automatic t_shared_strobe;
    ap(9'h000, 2'b00);
    ap(9'h088, 2'b11);
    ap(9'h100, 2'b11);
    ap(9'h000, 2'b00);
    $display("t_shared_strobe done");
  endtask
  task automatic t_set_reset;
    ap(9'h1CC, 2'b00);
    ap(9'h123, 2'b11);
    ap(9'h055, 2'b00);
    ap(9'h123, 2'b11);
    ap(9'h022, 2'b00);
    ap(9'h099, 2'b11);
    $display("t_set_reset done");
  endtask
  initial begin
    #10us bad_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_hold_capture();
    t_gate_only();
    t_shared_strobe();
    t_set_reset();
    end_of_test();
  end
endmodule // dual_latch_tb_top
